// ---- shared/crbs_pkg.sv ----
// Purpose: constants and types of the readback sequencer
// Assumes: 32-bit packet words, type 1 / type 2 header layout
// Notes:   offsets are register addresses inside packet headers
package crbs_pkg;
    localparam int          CRBS_WORD_W       = 32;
    localparam logic [31:0] CRBS_SYNC_WORD    = 32'hAA995566;
    // header field positions
    localparam int          CRBS_TYPE_MSB     = 31;
    localparam int          CRBS_TYPE_LSB     = 29;
    localparam int          CRBS_OP_MSB       = 28;
    localparam int          CRBS_OP_LSB       = 27;
    localparam int          CRBS_ADDR_MSB     = 26;
    localparam int          CRBS_ADDR_LSB     = 13;
    localparam int          CRBS_T1CNT_MSB    = 10;
    localparam int          CRBS_T2CNT_MSB    = 26;
    localparam int          CRBS_CMD_MSB      = 4;
    localparam logic [2:0]  CRBS_TYPE1        = 3'h1;
    localparam logic [2:0]  CRBS_TYPE2        = 3'h2;
    localparam logic [1:0]  CRBS_OP_READ      = 2'h1;
    localparam logic [1:0]  CRBS_OP_WRITE     = 2'h2;
    // packet register addresses
    localparam logic [13:0] CRBS_REG_FRAME_ADDRESS = 14'h0001;
    localparam logic [13:0] CRBS_REG_FRAME_READOUT = 14'h0003;
    localparam logic [13:0] CRBS_REG_CMD           = 14'h0004;
    // command codes
    localparam logic [4:0]  CRBS_CMD_READ_CONFIG    = 5'h04;
    localparam logic [4:0]  CRBS_CMD_START          = 5'h05;
    localparam logic [4:0]  CRBS_CMD_RESET_CHECKSUM = 5'h07;
    localparam logic [4:0]  CRBS_CMD_SHUTDOWN       = 5'h0B;
    localparam logic [4:0]  CRBS_CMD_DESYNCHRONIZE  = 5'h0D;
    // jtag instructions
    localparam logic [5:0]  CRBS_IR_CFG_IN    = 6'h05;
    localparam logic [5:0]  CRBS_IR_CFG_OUT   = 6'h04;
    localparam logic [5:0]  CRBS_IR_RST       = 6'h00;
    // timing counts and reset values
    localparam logic [1:0]  CRBS_RD_LAT_CYC   = 2'h3;
    localparam logic [1:0]  CRBS_FLUSH_WORDS  = 2'h2;
    localparam logic        CRBS_DONE_RST     = 1'b1;

    typedef enum logic [3:0] {
        CRBS_TLR = 4'hF, CRBS_RTI = 4'hC, CRBS_SEL_DR = 4'h7,
        CRBS_CAP_DR = 4'h6, CRBS_SH_DR = 4'h2, CRBS_EX1_DR = 4'h1,
        CRBS_PA_DR = 4'h3, CRBS_EX2_DR = 4'h0, CRBS_UPD_DR = 4'h5,
        CRBS_SEL_IR = 4'h4, CRBS_CAP_IR = 4'hE, CRBS_SH_IR = 4'hA,
        CRBS_EX1_IR = 4'h9, CRBS_PA_IR = 4'hB, CRBS_EX2_IR = 4'h8,
        CRBS_UPD_IR = 4'hD
    } crbs_tap_t;
endpackage : crbs_pkg

// ---- verilog/crbs_top.sv ----
// Purpose: device-side packet intake, shutdown/done control and
//          frame-memory readback over parallel port and jtag chains
// Assumes: parallel pins synchronous to CONFIG_CLOCK; jtag pins slow
//          against CLK_SYS; frame memory not written during readback
// Notes:
// Summary of operation
// - configuration-complete output is low while shutdown runs.
// - readout passes the frame buffer, one dummy frame comes first.
// - read data valid three config clocks after chip select asserts.
// - jtag input chain words are processed like parallel words.
// - readback commands via jtag input, data via jtag output chain.
// - direction low makes data pins inputs, high makes them outputs.
`timescale 1ns/10ps
`default_nettype none
module crbs_top
    import crbs_pkg::*;
#(
    parameter int WORDS_PER_FRAME = 4,
    parameter int NUM_FRAMES      = 8
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        CONFIG_CLOCK,
    input  wire logic        CFG_CS_N,
    input  wire logic        DIRECTION_SELECT,
    input  wire logic [31:0] CFG_D_I,
    output logic      [31:0] CFG_D_O,
    output logic             CFG_D_OE,
    output logic             CFG_DONE,
    input  wire logic        JTAG_TCK,
    input  wire logic        JTAG_TMS,
    input  wire logic        JTAG_TDI,
    output logic             JTAG_TDO,
    input  wire logic        MEM_WE,
    input  wire logic [$clog2(WORDS_PER_FRAME*NUM_FRAMES)-1:0] MEM_ADDR,
    input  wire logic [31:0] MEM_WDATA
);
    localparam int          DEPTH  = WORDS_PER_FRAME * NUM_FRAMES;
    localparam int          AW     = $clog2(DEPTH);
    localparam logic [31:0] WPF32  = 32'(WORDS_PER_FRAME);
    localparam logic [31:0] DEP32  = 32'(DEPTH);

    typedef struct packed {
        logic [2:0]  tck_s;     // [0] feeds [1] only
        logic [1:0]  tms_s;
        logic [1:0]  tdi_s;
        logic [2:0]  wtog_s;
        logic [2:0]  abort_s;
        logic [1:0]  fin_s;
        crbs_tap_t   tap;
        logic [5:0]  ir;
        logic [31:0] jsr;
        logic [4:0]  jbit;
        logic [31:0] jidx;
        logic        tdo;
        logic        synced;
        logic [26:0] left;
        logic [13:0] target;
        logic        rd_pend;
        logic        read_config_cmd;
        logic        started;
        logic [1:0]  flush;
        logic        done;
        logic        armed;
        logic [31:0] frame_address_reg;
        logic [31:0] len;
    } crbs_sys_t;

    typedef struct packed {
        logic [1:0][31:0] wbuf;  // ping-pong hand-over slots
        logic        wtog;
        logic        abort_tog;
        logic        dir_q;
        logic [1:0]  arm_s;      // [0] feeds [1] only
        logic [1:0]  lat;
        logic [31:0] idx;
        logic        fin;
        logic [31:0] d_o;
        logic        oe;
    } crbs_cfg_t;

    crbs_sys_t   s_q, s_d;
    crbs_cfg_t   c_q, c_d;
    logic [1:0]  rst_s;
    logic        c_rst;
    logic [31:0] mem [DEPTH];
    logic        tck_rise, tck_fall, jt_word, in_vld, shut_exec, c_load;
    logic [31:0] in_word;

    // readback word stream: dummy frame, requested frames, zeros past the memory end
    function automatic logic [31:0] rb_word(input logic [31:0] i,
                                            input logic [31:0] fa);
        logic [31:0] a;
        a = 32'h0;
        rb_word = 32'h0;
        if (i >= WPF32) begin
            a = fa * WPF32 + i - WPF32;
            if (a < DEP32) begin
                rb_word = mem[a[AW-1:0]];
            end
        end
    endfunction : rb_word

    // tap state walk
    function automatic crbs_tap_t tap_next(input crbs_tap_t t,
                                           input logic m);
        case (t)
            CRBS_TLR:    tap_next = m ? CRBS_TLR    : CRBS_RTI;
            CRBS_RTI:    tap_next = m ? CRBS_SEL_DR : CRBS_RTI;
            CRBS_SEL_DR: tap_next = m ? CRBS_SEL_IR : CRBS_CAP_DR;
            CRBS_CAP_DR: tap_next = m ? CRBS_EX1_DR : CRBS_SH_DR;
            CRBS_SH_DR:  tap_next = m ? CRBS_EX1_DR : CRBS_SH_DR;
            CRBS_EX1_DR: tap_next = m ? CRBS_UPD_DR : CRBS_PA_DR;
            CRBS_PA_DR:  tap_next = m ? CRBS_EX2_DR : CRBS_PA_DR;
            CRBS_EX2_DR: tap_next = m ? CRBS_UPD_DR : CRBS_SH_DR;
            CRBS_SEL_IR: tap_next = m ? CRBS_TLR    : CRBS_CAP_IR;
            CRBS_CAP_IR: tap_next = m ? CRBS_EX1_IR : CRBS_SH_IR;
            CRBS_SH_IR:  tap_next = m ? CRBS_EX1_IR : CRBS_SH_IR;
            CRBS_EX1_IR: tap_next = m ? CRBS_UPD_IR : CRBS_PA_IR;
            CRBS_PA_IR:  tap_next = m ? CRBS_EX2_IR : CRBS_PA_IR;
            CRBS_EX2_IR: tap_next = m ? CRBS_UPD_IR : CRBS_SH_IR;
            default:     tap_next = m ? CRBS_SEL_DR : CRBS_RTI;
        endcase
    endfunction : tap_next

    // frame memory load port
    always_ff @(posedge CLK_SYS) begin
        if (MEM_WE) begin
            mem[MEM_ADDR] <= MEM_WDATA;
        end
    end

    // word intake: a finished jtag word or a parallel hand-over
    assign tck_rise = s_q.tck_s[1] & ~s_q.tck_s[2];
    assign tck_fall = ~s_q.tck_s[1] & s_q.tck_s[2];
    assign jt_word  = tck_rise && s_q.tap == CRBS_SH_DR
                      && s_q.ir == CRBS_IR_CFG_IN && s_q.jbit == 5'h1F;
    assign in_vld   = jt_word || (s_q.wtog_s[2] ^ s_q.wtog_s[1]);
    assign in_word  = jt_word ? {s_q.jsr[30:0], s_q.tdi_s[1]}
                              : c_q.wbuf[~s_q.wtog_s[1]];
    assign shut_exec = in_vld && s_q.synced && s_q.left != 27'h0
                       && s_q.target == CRBS_REG_CMD
                       && in_word[CRBS_CMD_MSB:0] == CRBS_CMD_SHUTDOWN;

    // system domain: tap, packet processor, done control
    always_comb begin
        s_d = s_q;
        s_d.tck_s   = {s_q.tck_s[1:0], JTAG_TCK};
        s_d.tms_s   = {s_q.tms_s[0], JTAG_TMS};
        s_d.tdi_s   = {s_q.tdi_s[0], JTAG_TDI};
        s_d.wtog_s  = {s_q.wtog_s[1:0], c_q.wtog};
        s_d.abort_s = {s_q.abort_s[1:0], c_q.abort_tog};
        s_d.fin_s   = {s_q.fin_s[0], c_q.fin};
        if (tck_rise) begin
            s_d.tap = tap_next(s_q.tap, s_q.tms_s[1]);
            case (s_q.tap)
                CRBS_TLR: s_d.ir = CRBS_IR_RST;
                CRBS_SH_IR: s_d.ir = {s_q.tdi_s[1], s_q.ir[5:1]};
                CRBS_CAP_DR: begin
                    s_d.jbit = 5'h0;
                    if (s_q.ir == CRBS_IR_CFG_OUT && s_q.armed) begin
                        s_d.jsr  = rb_word(s_q.jidx, s_q.frame_address_reg);
                        s_d.jidx = s_q.jidx + 32'h1;
                    end
                end
                CRBS_SH_DR: begin
                    s_d.jbit = s_q.jbit + 5'h1;
                    s_d.jsr  = {s_q.jsr[30:0], s_q.tdi_s[1]};
                    if (s_q.ir == CRBS_IR_CFG_OUT && s_q.jbit == 5'h1F) begin
                        s_d.jsr  = s_q.armed
                                   ? rb_word(s_q.jidx, s_q.frame_address_reg) : 32'h0;
                        s_d.jidx = s_q.jidx + 32'h1;
                    end
                end
                default: s_d.jbit = s_q.jbit;
            endcase
        end
        if (tck_fall) begin
            s_d.tdo = (s_q.tap == CRBS_SH_DR) ? s_q.jsr[31]
                    : (s_q.tap == CRBS_SH_IR) ? s_q.ir[0] : 1'b0;
        end
        // packet processor
        if (in_vld) begin
            if (!s_q.synced) begin
                if (in_word == CRBS_SYNC_WORD) begin
                    s_d.synced = 1'b1;
                    s_d.left   = 27'h0;
                end else if (s_q.flush != 2'h0) begin
                    s_d.flush = s_q.flush - 2'h1;
                    s_d.done  = (s_q.flush == 2'h1);
                end
            end else if (s_q.left != 27'h0) begin
                s_d.left = s_q.left - 27'h1;
                if (s_q.target == CRBS_REG_FRAME_ADDRESS) begin
                    s_d.frame_address_reg = in_word;
                end else if (s_q.target == CRBS_REG_CMD) begin
                    case (in_word[CRBS_CMD_MSB:0])
                        CRBS_CMD_SHUTDOWN: begin
                            s_d.done    = 1'b0;
                            s_d.started = 1'b0;
                        end
                        CRBS_CMD_READ_CONFIG: s_d.read_config_cmd = 1'b1;
                        CRBS_CMD_START: s_d.started = 1'b1;
                        CRBS_CMD_DESYNCHRONIZE: begin
                            s_d.synced = 1'b0;
                            s_d.read_config_cmd   = 1'b0;
                            s_d.flush  = s_q.started ? CRBS_FLUSH_WORDS
                                                     : 2'h0;
                        end
                        default: s_d.left = s_q.left - 27'h1;
                    endcase
                end
            end else if (in_word[CRBS_TYPE_MSB:CRBS_TYPE_LSB] == CRBS_TYPE1)
            begin
                s_d.target = in_word[CRBS_ADDR_MSB:CRBS_ADDR_LSB];
                if (in_word[CRBS_OP_MSB:CRBS_OP_LSB] == CRBS_OP_WRITE) begin
                    s_d.left = 27'(in_word[CRBS_T1CNT_MSB:0]);
                end
                s_d.rd_pend = in_word[CRBS_OP_MSB:CRBS_OP_LSB] == CRBS_OP_READ
                    && in_word[CRBS_ADDR_MSB:CRBS_ADDR_LSB]
                       == CRBS_REG_FRAME_READOUT;
            end else if (in_word[CRBS_TYPE_MSB:CRBS_TYPE_LSB] == CRBS_TYPE2)
            begin
                if (in_word[CRBS_OP_MSB:CRBS_OP_LSB] == CRBS_OP_WRITE) begin
                    s_d.left = in_word[CRBS_T2CNT_MSB:0];
                end else if (s_q.rd_pend && s_q.read_config_cmd) begin
                    s_d.len   = 32'(in_word[CRBS_T2CNT_MSB:0]);
                    s_d.armed = 1'b1;
                    s_d.jidx  = 32'h0;
                end
                s_d.rd_pend = 1'b0;
            end
        end
        // readout ends when the parallel side has sent all words or the jtag index passes len
        if (s_q.armed && s_q.fin_s[1]) begin
            s_d.armed = 1'b0;
        end
        if (s_q.armed && s_q.jidx > s_q.len) begin
            s_d.armed = 1'b0;
        end
        // direction change while selected resets the parser
        if (s_q.abort_s[2] ^ s_q.abort_s[1]) begin
            s_d.synced  = 1'b0;
            s_d.left    = 27'h0;
            s_d.rd_pend = 1'b0;
            s_d.armed   = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s_q      <= '0;
            s_q.tap  <= CRBS_TLR;
            s_q.done <= CRBS_DONE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // reset synchroniser into the config clock domain
    always_ff @(posedge CONFIG_CLOCK) begin
        rst_s <= {rst_s[0], SYS_RST};
    end
    assign c_rst  = rst_s[1];
    assign c_load = !CFG_CS_N && DIRECTION_SELECT && c_q.arm_s[1]
                    && !c_q.fin && c_q.lat == CRBS_RD_LAT_CYC - 2'h1;

    // config clock domain: parallel write capture and readout
    always_comb begin
        c_d = c_q;
        c_d.arm_s = {c_q.arm_s[0], s_q.armed};
        c_d.dir_q = DIRECTION_SELECT;
        c_d.oe    = DIRECTION_SELECT;
        if (!CFG_CS_N && !DIRECTION_SELECT) begin
            c_d.wbuf[c_q.wtog] = CFG_D_I;
            c_d.wtog = ~c_q.wtog;
        end
        if (!CFG_CS_N && DIRECTION_SELECT != c_q.dir_q) begin
            c_d.abort_tog = ~c_q.abort_tog;
        end
        if (CFG_CS_N || !DIRECTION_SELECT) begin
            c_d.lat = 2'h0;
        end else if (c_load) begin
            c_d.d_o = rb_word(c_q.idx, s_q.frame_address_reg);
            c_d.idx = c_q.idx + 32'h1;
            c_d.fin = (c_q.idx + 32'h1 == s_q.len);
        end else if (c_q.arm_s[1] && !c_q.fin) begin
            c_d.lat = c_q.lat + 2'h1;
        end
        if (!c_q.arm_s[1]) begin
            c_d.fin = 1'b0;
            c_d.idx = 32'h0;
        end
    end

    always_ff @(posedge CONFIG_CLOCK) begin
        if (c_rst) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign CFG_D_O  = c_q.d_o;
    assign CFG_D_OE = c_q.oe;
    assign CFG_DONE = s_q.done;
    assign JTAG_TDO = s_q.tdo;

    // checks
    done_low_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        shut_exec |=> !CFG_DONE ##1 (!CFG_DONE || s_q.started))
        else $error("complete output not low after shutdown");
    done_hold_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (!CFG_DONE && !s_q.started) |=> !CFG_DONE)
        else $error("complete output rose before start");
    read_lat_a: assert property (@(posedge CONFIG_CLOCK)
        disable iff (c_rst)
        ($fell(CFG_CS_N) && DIRECTION_SELECT && c_q.arm_s[1] && !c_q.fin
         && c_q.idx == 32'h0) ##0 (!CFG_CS_N && DIRECTION_SELECT)[*3]
        |=> CFG_D_OE && c_q.idx == 32'h1
            && CFG_D_O == rb_word(32'h0, s_q.frame_address_reg))
        else $error("first readback word not valid after three clocks");
    dummy_frame_a: assert property (@(posedge CONFIG_CLOCK)
        disable iff (c_rst)
        (c_load && c_q.idx < WPF32) |=> CFG_D_O == 32'h0)
        else $error("dummy frame word not zero");
    dir_drive_a: assert property (@(posedge CONFIG_CLOCK)
        disable iff (c_rst)
        1'b1 |=> CFG_D_OE == $past(DIRECTION_SELECT))
        else $error("data drive does not follow direction");
    word_take_a: assert property (@(posedge CONFIG_CLOCK)
        disable iff (c_rst)
        (!CFG_CS_N && !DIRECTION_SELECT) |=> c_q.wtog != $past(c_q.wtog)
        && c_q.wbuf[$past(c_q.wtog)] == $past(CFG_D_I))
        else $error("written word not captured");
    // a sync word shifted in through the input chain must lock the parser
    jtag_in_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (jt_word && !s_q.synced
         && {s_q.jsr[30:0], s_q.tdi_s[1]} == CRBS_SYNC_WORD)
        |=> s_q.synced)
        else $error("jtag word not passed to packet processor");
    jtag_out_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (tck_fall && s_q.tap == CRBS_SH_DR && s_q.ir == CRBS_IR_CFG_OUT)
        |=> JTAG_TDO == $past(s_q.jsr[31]))
        else $error("output chain bit not presented");
endmodule : crbs_top
`default_nettype wire

// ---- test/crbs_ctrl_model.sv ----
// Purpose: controller model driving the parallel configuration port
// Assumes: clock pulses only while the bench asks for them
// Notes:   released data lines toggle every cycle
`timescale 1ns/10ps
`default_nettype none
module crbs_ctrl_model (
    output logic        config_clock,
    output logic        cs_n,
    output logic        direction_select,
    output logic [31:0] d_i
);
    // idle pins at time zero
    initial begin
        config_clock     = 1'b0;
        cs_n             = 1'b1;
        direction_select = 1'b0;
        d_i              = 32'h0;
    end
    // one clock period; pins change only while the clock is low
    task automatic cyc();
        if (cs_n || direction_select) begin
            d_i = ~d_i; // released lines keep no stale value
        end
        #7.5 config_clock = 1'b1;
        #7.5 config_clock = 1'b0;
    endtask : cyc
    // clocks with chip select off
    task automatic idle(input int n);
        cs_n = 1'b1;
        repeat (n) cyc();
    endtask : idle
    // one whole word in write direction
    task automatic wr(input logic [31:0] w);
        cs_n = 1'b0;
        d_i  = w;
        cyc();
    endtask : wr
    // direction changes only with chip select off
    task automatic turn(input logic dir);
        idle(1);
        direction_select = dir;
        cyc();
    endtask : turn
    // direction flip while selected, used only to force an abort
    task automatic abort();
        direction_select = ~direction_select;
        cyc();
        turn(1'b0);
    endtask : abort
    // select for reading; first word shows after the third edge
    task automatic rd_start();
        cs_n = 1'b0;
        repeat (3) cyc();
    endtask : rd_start
endmodule : crbs_ctrl_model
`default_nettype wire

// ---- test/crbs_top_tb.sv ----
// Purpose: self-checking bench for the readback sequencer
// Assumes: frame memory is loaded before any readout
// Notes:   expected readout comes from a bench copy of the memory
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
    end \
end
module crbs_top_tb;
    import crbs_pkg::*;
    localparam int          WPF        = 4;
    localparam int          NF         = 8;
    localparam logic [31:0] NO_OP_WORD = 32'h20000000;
    localparam logic [19:0] TAP_WALK   = 20'h380DF;
    logic        clk_sys, sys_rst, config_clock, cfg_cs_n, direction_select;
    logic        cfg_d_oe, cfg_done, mem_we;
    logic        jtag_tck, jtag_tms, jtag_tdi, jtag_tdo;
    logic [31:0] cfg_d_i, cfg_d_o, mem_wdata, got;
    logic [4:0]  mem_addr;
    logic [31:0] mem [32];
    logic [31:0] pk [$];
    int          failures = 0;
    int          checked  = 0;
    int          cycles   = 0;

    crbs_top #(.WORDS_PER_FRAME(WPF), .NUM_FRAMES(NF)) i_crbs_top (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CONFIG_CLOCK(config_clock),
        .CFG_CS_N(cfg_cs_n), .DIRECTION_SELECT(direction_select),
        .CFG_D_I(cfg_d_i), .CFG_D_O(cfg_d_o), .CFG_D_OE(cfg_d_oe),
        .CFG_DONE(cfg_done), .JTAG_TCK(jtag_tck), .JTAG_TMS(jtag_tms),
        .JTAG_TDI(jtag_tdi), .JTAG_TDO(jtag_tdo), .MEM_WE(mem_we),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata)
    );
    crbs_ctrl_model i_crbs_ctrl_model (
        .config_clock(config_clock), .cs_n(cfg_cs_n),
        .direction_select(direction_select), .d_i(cfg_d_i)
    );
    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // dummy frame first, then memory, zeros past its end
    function automatic logic [31:0] exp_word(input int fa, input int i);
        int a;
        a = fa * WPF + i - WPF;
        if (i < WPF || a >= WPF * NF) begin
            return 32'h0;
        end
        return mem[a];
    endfunction : exp_word
    // packet queue helpers
    task automatic put(input logic [31:0] w);
        pk.push_back(w);
    endtask : put
    task automatic put_cmd(input logic [4:0] c);
        put(32'h30008001);
        put({27'h0, c});
        put(NO_OP_WORD);
    endtask : put_cmd
    task automatic put_sync();
        put(32'hFFFFFFFF);
        put(32'h000000BB);
        put(32'h11220044);
        put(32'hFFFFFFFF);
        put(CRBS_SYNC_WORD);
        put(NO_OP_WORD);
    endtask : put_sync
    task automatic put_arm(input logic [31:0] fa, input logic [31:0] cnt);
        put_cmd(CRBS_CMD_READ_CONFIG);
        put(32'h30002001);
        put(fa);
        put(32'h28006000);
        put(32'h48000000 | cnt);
    endtask : put_arm
    task automatic send_par();
        foreach (pk[i]) begin
            i_crbs_ctrl_model.wr(pk[i]);
        end
        pk.delete();
        repeat (10) @(negedge clk_sys);
    endtask : send_par
    // one tck period, pins set on falling system clock
    task automatic jtag_bit(input logic tms, input logic tdi,
                            output logic tdo);
        @(negedge clk_sys);
        jtag_tms = tms;
        jtag_tdi = tdi;
        repeat (8) @(negedge clk_sys);
        tdo      = jtag_tdo;
        jtag_tck = 1'b1;
        repeat (8) @(negedge clk_sys);
        jtag_tck = 1'b0;
    endtask : jtag_bit
    task automatic jtag_dr(input logic [31:0] w, input logic last,
                           output logic [31:0] r);
        for (int b = 31; b >= 0; b--) begin
            jtag_bit(last && b == 0, w[b], r[b]);
        end
    endtask : jtag_dr
    // reset, walk to shift-ir, load, walk on to shift-dr
    task automatic jtag_ir(input logic [5:0] ir);
        logic o;
        for (int i = 0; i < 20; i++) begin
            jtag_bit(TAP_WALK[i], (i >= 10 && i < 16) ? ir[i - 10] : 1'b0, o);
        end
    endtask : jtag_ir
    // main sequence
    initial begin
        sys_rst = 1'b1;
        {jtag_tck, jtag_tms, jtag_tdi, mem_we} = 4'h0;
        mem_addr  = 5'h0;
        mem_wdata = 32'h0;
        void'($urandom(32'hF1E9A359));
        fork
            repeat (12) @(negedge clk_sys);
            i_crbs_ctrl_model.idle(4);
        join
        sys_rst = 1'b0;
        i_crbs_ctrl_model.idle(4);
        `CHK(cfg_done, CRBS_DONE_RST)
        `CHK({cfg_d_oe, jtag_tdo}, 2'h0)
        for (int a = 0; a < WPF * NF; a++) begin
            @(negedge clk_sys);
            mem_we    = 1'b1;
            mem_addr  = 5'(a);
            mem_wdata = $urandom;
            mem[a]    = mem_wdata;
        end
        @(negedge clk_sys);
        mem_we = 1'b0;
        put_cmd(CRBS_CMD_SHUTDOWN);
        send_par();
        `CHK(cfg_done, 1'b1)
        put_sync();
        send_par();
        i_crbs_ctrl_model.abort();
        put_cmd(CRBS_CMD_SHUTDOWN);
        send_par();
        `CHK(cfg_done, 1'b1)
        put_sync();
        put_cmd(CRBS_CMD_SHUTDOWN);
        put_cmd(CRBS_CMD_RESET_CHECKSUM);
        repeat (5) put(NO_OP_WORD);
        send_par();
        `CHK(cfg_done, 1'b0)
        put_arm(32'd5, 32'd26);
        repeat (64) put(NO_OP_WORD);
        send_par();
        i_crbs_ctrl_model.turn(1'b1);
        `CHK(cfg_d_oe, 1'b1)
        i_crbs_ctrl_model.rd_start();
        for (int i = 0; i < 26; i++) begin
            if (i > 0) begin
                i_crbs_ctrl_model.cyc();
            end
            `CHK(cfg_d_o, exp_word(5, i))
        end
        i_crbs_ctrl_model.turn(1'b0);
        `CHK(cfg_d_oe, 1'b0)
        put(NO_OP_WORD);
        put_cmd(CRBS_CMD_START);
        put_cmd(CRBS_CMD_RESET_CHECKSUM);
        send_par();
        `CHK(cfg_done, 1'b0)
        put(32'h30008001);
        put({27'h0, CRBS_CMD_DESYNCHRONIZE});
        put(NO_OP_WORD);
        put(NO_OP_WORD);
        send_par();
        for (int k = 0; k < 4 && cfg_done !== 1'b1; k++) begin
            put(NO_OP_WORD);
            send_par();
        end
        `CHK(cfg_done, 1'b1)
        jtag_ir(CRBS_IR_CFG_IN);
        put_sync();
        put_arm(32'd0, 32'd18);
        put(NO_OP_WORD);
        foreach (pk[i]) begin
            jtag_dr(pk[i], i == pk.size() - 1, got);
        end
        pk.delete();
        jtag_ir(CRBS_IR_CFG_OUT);
        for (int i = 0; i < 18; i++) begin
            jtag_dr(32'h0, i == 17, got);
            `CHK(got, exp_word(0, i))
        end
        repeat (5) jtag_bit(1'b1, 1'b0, got[0]);
        wrap_up();
    end
endmodule : crbs_top_tb
`default_nettype wire
